// [eipl_defs.svh]
`ifndef EIPL_DEFS_SVH
`define EIPL_DEFS_SVH

// Register map, byte addresses on the APB
`define EIPL_ADDR_W            12
`define EIPL_STATUS_CTRL_ADDR  12'h000

// Field positions in ext_int_status_control
`define EIPL_MODE_BIT          0
`define EIPL_MASK_BIT          1
`define EIPL_ACK_BIT           2
`define EIPL_PEND_BIT          3
`define EIPL_CTRL_RESET        8'h00

// Vector locations loaded into the program counter
`define EIPL_VECTOR_HI_ADDR    16'hFFFA
`define EIPL_VECTOR_LO_ADDR    16'hFFFB

`endif

// [eipl_pin_dev.sv]
`timescale 1ns/1ps

module eipl_pin_dev
(
   // Clock
   input  wire logic clk,
   // Bench request: hold the line low
   input  wire logic low_req,
   input  wire logic slow,
   // Active-low interrupt line
   output logic      pin_n
);
   logic [2:0] hist;

   ////////////////////////////////////////////////////////////////////////////
   // Slow answer lags the request by three clocks; the line is always driven
   always_ff @(posedge clk)
   begin
      hist <= {hist[1:0], low_req};
   end

   assign pin_n = ~(slow ? hist[2] : low_req);
endmodule : eipl_pin_dev

// [eipl_pin_if.sv]
`timescale 1ns/1ps

interface eipl_pin_if;
   logic pin_level;
   logic pin_fall;

   modport src (output pin_level, output pin_fall);
   modport dst (input  pin_level, input  pin_fall);
endinterface : eipl_pin_if

// [eipl_pin_sync.sv]
`timescale 1ns/1ps

module eipl_pin_sync
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Raw active-low pin
   input  wire logic pin_n,
   // Synchronised view
   eipl_pin_if.src   pin
);

   logic       meta;
   logic       sync;
   logic       prev;
   logic [1:0] settled;

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser, meta is read by sync only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= 1'b1;
         sync <= 1'b1;
      end
      else
      begin
         meta <= pin_n;
         sync <= meta;
      end
   end

   // Reset preset is no real sample: a pin held low through reset must not look like an edge
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         settled <= 2'b00;
      else
         settled <= {settled[0], 1'b1};
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prev <= 1'b0;
      else
         prev <= sync & settled[1];
   end

   assign pin.pin_level = sync;
   assign pin.pin_fall  = prev & ~sync;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_high_then_low;
      settled[1] && sync ##1 !sync;
   endsequence

   property p_fall_detect;
      s_high_then_low |-> pin.pin_fall;
   endproperty
   a_fall_detect : assert property (p_fall_detect)
      else $error("falling edge of synchronised pin not flagged");

endmodule : eipl_pin_sync

// [eipl_pkg.sv]
package eipl_pkg;

   // Sensitivity select, in register bit order
   typedef enum logic {EIPL_EDGE_ONLY, EIPL_EDGE_LEVEL} eipl_mode_e;

   typedef logic [7:0] eipl_reg_t;

endpackage : eipl_pkg

// [eipl_top.sv]
// How it works
// - Falling pin edge sets the latch
// - Vector fetch acknowledges and clears the latch
// - Writing one to ack clears the latch
// - Reset clears latch, selects edge-only
// - Edge-only: acknowledge clears at once
// - Edge-level: clear needs ack and high pin
// - Edge-level: stays pending while pin low
// - Later falling edge latches a new request
// - Mask bit keeps request from priority logic
// - Processor global mask also blocks request
// - Vector fetched from two fixed addresses
// - Pending flag readable, independent of mask
// - Ack bit write-only, reads zero
// - Mask bit read/write, reset to zero
// - Sensitivity bit read/write, reset to zero
// - Break without clear-enable blocks software ack
// - Break with clear-enable permits lasting clear
// - Pin level offered to branch instructions
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "eipl_defs.svh"

module eipl_top
(
   // Clock and reset
   input  wire logic                       SYS_CLK,
   input  wire logic                       RST,
   // APB slave
   input  wire logic                       PSEL,
   input  wire logic                       PENABLE,
   input  wire logic                       PWRITE,
   input  wire logic [`EIPL_ADDR_W-1:0]    PADDR,
   input  wire logic [31:0]                PWDATA,
   input  wire logic [3:0]                 PSTRB,
   output logic      [31:0]                PRDATA,
   output logic                            PREADY,
   output logic                            PSLVERR,
   // External pin, active low, asynchronous
   input  wire logic                       EXT_INT_PIN_N,
   // Processor side
   input  wire logic                       VECTOR_FETCH,
   input  wire logic                       CCW_INT_MASK,
   input  wire logic                       BREAK_STATE,
   input  wire logic                       BREAK_CLEAR_ENABLE,
   output logic                            INT_REQUEST,
   output logic                            PIN_LEVEL,
   output logic      [15:0]                VECTOR_HI_ADDR,
   output logic      [15:0]                VECTOR_LO_ADDR
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   eipl_pin_if            pin ();

   logic                  latch;
   logic                  next_latch;
   logic                  ack_pend;
   logic                  next_ack_pend;
   logic                  pin_request_mask;
   eipl_pkg::eipl_mode_e  mode;

   logic                  setup;
   logic                  access_done;
   logic                  hit;
   logic                  wr_ctrl;
   logic                  sw_ack_req;
   logic                  sw_ack;
   logic                  ack;
   logic                  pin_high;

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic addr_hit(input logic [`EIPL_ADDR_W-1:0] addr);
      return addr == `EIPL_STATUS_CTRL_ADDR;
   endfunction : addr_hit

   function automatic eipl_pkg::eipl_reg_t status_word(input logic pend,
                                                       input logic msk,
                                                       input logic md);
      eipl_pkg::eipl_reg_t w;
      w                  = `EIPL_CTRL_RESET;
      w[`EIPL_PEND_BIT]  = pend;
      w[`EIPL_MASK_BIT]  = msk;
      w[`EIPL_MODE_BIT]  = md;
      w[`EIPL_ACK_BIT]   = 1'b0;
      return w;
   endfunction : status_word

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and edge detector

   eipl_pin_sync u_pin_sync
   (
      .clk   (SYS_CLK),
      .rst   (RST),
      .pin_n (EXT_INT_PIN_N),
      .pin   (pin.src)
   );

   assign pin_high = pin.pin_level;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   assign setup       = PSEL & ~PENABLE;
   assign access_done = PSEL & PENABLE & PREADY;
   assign hit         = addr_hit(PADDR);
   assign wr_ctrl     = access_done & PWRITE & hit & PSTRB[0];

   // Ack strobe is held only in ack_pend (edge-level mode), which the status word never shows, so it reads back zero
   assign sw_ack_req  = wr_ctrl & PWDATA[`EIPL_ACK_BIT];
   // Break without clear-enable protects the latch from software ack; vector fetch still clears it
   assign sw_ack      = sw_ack_req & ~(BREAK_STATE & ~BREAK_CLEAR_ENABLE);
   assign ack         = VECTOR_FETCH | sw_ack;

   // Zero-wait slave: ready is raised for exactly the access cycle
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         PREADY <= 1'b0;
      else
         PREADY <= setup;
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         PSLVERR <= 1'b0;
      else
         PSLVERR <= setup & ~hit;
   end

   // Read data sampled in the setup cycle
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         PRDATA <= 32'h0000_0000;
      else if (setup & ~PWRITE & hit)
         PRDATA <= {24'h00_0000, status_word(latch, pin_request_mask, mode)};
      else
         PRDATA <= 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control bits

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         pin_request_mask <= 1'(`EIPL_CTRL_RESET >> `EIPL_MASK_BIT);
      else if (wr_ctrl)
         pin_request_mask <= PWDATA[`EIPL_MASK_BIT];
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         mode <= eipl_pkg::EIPL_EDGE_ONLY;
      else if (wr_ctrl)
         mode <= eipl_pkg::eipl_mode_e'(PWDATA[`EIPL_MODE_BIT]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt latch

   always_comb
   begin
      next_latch    = latch;
      next_ack_pend = ack_pend;
      if (latch)
      begin
         unique case (mode)
            eipl_pkg::EIPL_EDGE_ONLY:
            begin
               if (ack)
                  next_latch = 1'b0;
            end
            eipl_pkg::EIPL_EDGE_LEVEL:
            begin
               // Ack and high pin may come in either order
               if ((ack | ack_pend) & pin_high)
                  next_latch = 1'b0;
               else if (ack)
                  next_ack_pend = 1'b1;
            end
         endcase
      end
      if (!next_latch)
         next_ack_pend = 1'b0;
      // A new edge wins over any clear in the same cycle
      if (pin.pin_fall)
      begin
         next_latch    = 1'b1;
         next_ack_pend = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         latch <= 1'b0;
      else
         latch <= next_latch;
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         ack_pend <= 1'b0;
      else
         ack_pend <= next_ack_pend;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Processor-facing outputs

   // Both the local mask and the global mask gate the request
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         INT_REQUEST <= 1'b0;
      else
         INT_REQUEST <= next_latch & ~pin_request_mask & ~CCW_INT_MASK;
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         PIN_LEVEL <= 1'b1;
      else
         PIN_LEVEL <= pin.pin_level;
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         VECTOR_HI_ADDR <= `EIPL_VECTOR_HI_ADDR;
         VECTOR_LO_ADDR <= `EIPL_VECTOR_LO_ADDR;
      end
      else
      begin
         VECTOR_HI_ADDR <= `EIPL_VECTOR_HI_ADDR;
         VECTOR_LO_ADDR <= `EIPL_VECTOR_LO_ADDR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   sequence s_sw_ack_edge;
      latch && mode == eipl_pkg::EIPL_EDGE_ONLY && sw_ack_req && !pin.pin_fall;
   endsequence

   sequence s_level_wait;
      latch && mode == eipl_pkg::EIPL_EDGE_LEVEL && ack && !pin_high && !pin.pin_fall;
   endsequence

   property p_edge_sets;
      pin.pin_fall |=> latch;
   endproperty
   a_edge_sets : assert property (p_edge_sets)
      else $error("falling edge did not set the latch");

   property p_vector_clear;
      latch && mode == eipl_pkg::EIPL_EDGE_ONLY && VECTOR_FETCH && !pin.pin_fall |=> !latch;
   endproperty
   a_vector_clear : assert property (p_vector_clear)
      else $error("vector fetch did not clear the latch");

   property p_sw_clear;
      (s_sw_ack_edge and !BREAK_STATE) |=> !latch ##1 (latch == $past(pin.pin_fall));
   endproperty
   a_sw_clear : assert property (p_sw_clear)
      else $error("software ack did not clear the latch");

   property p_reset_state;
      $fell(RST) |-> !latch && mode == eipl_pkg::EIPL_EDGE_ONLY && !pin_request_mask;
   endproperty
   a_reset_state : assert property (p_reset_state)
      else $error("reset did not clear latch and controls");

   property p_level_holds;
      s_level_wait ##1 (!pin_high && !pin.pin_fall)[*2] |-> latch && ack_pend;
   endproperty
   a_level_holds : assert property (p_level_holds)
      else $error("level mode latch dropped while pin low");

   property p_level_release;
      latch && mode == eipl_pkg::EIPL_EDGE_LEVEL && ack_pend && pin_high && !pin.pin_fall |=> !latch;
   endproperty
   a_level_release : assert property (p_level_release)
      else $error("level mode latch not cleared on pin high");

   property p_mask_blocks;
      pin_request_mask || CCW_INT_MASK |=> !INT_REQUEST;
   endproperty
   a_mask_blocks : assert property (p_mask_blocks)
      else $error("request presented while masked");

   property p_request_follows;
      latch && !pin_request_mask && !CCW_INT_MASK && !ack && !(ack_pend && pin_high) |=> INT_REQUEST;
   endproperty
   a_request_follows : assert property (p_request_follows)
      else $error("unmasked pending request not presented");

   property p_read_status;
      setup && !PWRITE && hit |=> PRDATA[`EIPL_PEND_BIT] == $past(latch)
                                  && PRDATA[`EIPL_ACK_BIT] == 1'b0
                                  && PRDATA[31:4] == 28'h000_0000
                                  && PRDATA[`EIPL_MASK_BIT] == $past(pin_request_mask);
   endproperty
   a_read_status : assert property (p_read_status)
      else $error("status read returned wrong value");

   property p_write_ctrl;
      wr_ctrl |=> pin_request_mask == $past(PWDATA[`EIPL_MASK_BIT])
                  && mode == $past(PWDATA[`EIPL_MODE_BIT]);
   endproperty
   a_write_ctrl : assert property (p_write_ctrl)
      else $error("control write not stored");

   property p_break_protect;
      (s_sw_ack_edge and (BREAK_STATE && !BREAK_CLEAR_ENABLE && !VECTOR_FETCH)) |=> latch;
   endproperty
   a_break_protect : assert property (p_break_protect)
      else $error("software ack cleared latch during protected break");

   property p_break_clear;
      (s_sw_ack_edge and (BREAK_STATE && BREAK_CLEAR_ENABLE)) ##1 (!pin.pin_fall)[*2] |-> !latch;
   endproperty
   a_break_clear : assert property (p_break_clear)
      else $error("latch cleared in break did not stay cleared");

   property p_pin_level;
      ##1 1'b1 |-> PIN_LEVEL == $past(pin.pin_level);
   endproperty
   a_pin_level : assert property (p_pin_level)
      else $error("pin level output lags wrongly");

   property p_vector_addr;
      VECTOR_HI_ADDR == `EIPL_VECTOR_HI_ADDR && VECTOR_LO_ADDR == VECTOR_HI_ADDR + 16'h0001;
   endproperty
   a_vector_addr : assert property (p_vector_addr)
      else $error("vector addresses wrong");

   property p_apb_ready;
      setup |=> PREADY ##1 !PREADY || (PSEL && !PENABLE);
   endproperty
   a_apb_ready : assert property (p_apb_ready)
      else $error("ready not a single access cycle");

endmodule : eipl_top

// [eipl_top_test.sv]
`timescale 1ns/1ps
`include "eipl_defs.svh"

module eipl_top_test;
   logic                    sys_clk;
   logic                    rst;
   logic                    psel;
   logic                    penable;
   logic                    pwrite;
   logic [`EIPL_ADDR_W-1:0] paddr;
   logic [31:0]             pwdata;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic                    low_req;
   logic                    slow;
   logic                    pin_n;
   logic                    vfetch;
   logic                    ccw_mask;
   logic                    brk;
   logic                    brk_clr;
   logic                    int_req;
   logic                    pin_level;
   logic [15:0]             vec_hi;
   logic [15:0]             vec_lo;
   logic [31:0]             rd;
   logic                    err;
   int                      errors;
   int                      num_checks;
   int                      cycles;

   eipl_pin_dev dev_u (.clk(sys_clk), .low_req(low_req), .slow(slow), .pin_n(pin_n));

   eipl_top dut_u
   (
      .SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'h1), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .EXT_INT_PIN_N(pin_n), .VECTOR_FETCH(vfetch), .CCW_INT_MASK(ccw_mask),
      .BREAK_STATE(brk), .BREAK_CLEAR_ENABLE(brk_clr), .INT_REQUEST(int_req),
      .PIN_LEVEL(pin_level), .VECTOR_HI_ADDR(vec_hi), .VECTOR_LO_ADDR(vec_lo)
   );

   ////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Entered and left just after a rising edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
      chk("access_cycles", 32'h1, n);
   endtask : apb

   task wr(input logic [7:0] d);
      apb(1'b1, `EIPL_STATUS_CTRL_ADDR, {24'h0, d});
   endtask : wr

   task rd_chk(input logic [7:0] exp);
      apb(1'b0, `EIPL_STATUS_CTRL_ADDR, 32'h0);
      chk("status", {24'h0, exp}, rd);
   endtask : rd_chk

   // Pin falls reach the request output within a bounded number of clocks
   task wait_req(input logic v);
      int n;
      n = 0;
      while (int_req !== v && n < 10)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk("int_request", {31'h0, v}, {31'h0, int_req});
   endtask : wait_req

   task fall;
      low_req <= 1'b1;
      wait_req(1'b1);
   endtask : fall

   task rise;
      low_req <= 1'b0;
      repeat (5) @(posedge sys_clk);
   endtask : rise

   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd_chk(8'h00);
      chk("pin_level", 32'h1, {31'h0, pin_level});
      chk("vec_hi", 32'h0000FFFA, {16'h0, vec_hi});
      chk("vec_lo", 32'h0000FFFB, {16'h0, vec_lo});
      apb(1'b0, 12'h004, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("unmapped", 32'h0, rd);
      apb(1'b1, `EIPL_STATUS_CTRL_ADDR, 32'hFFFFFFF0);
      rd_chk(8'h00);
   endtask : t_reset

   task t_edge;
      slow <= 1'b1;
      fall();
      chk("pin_level", 32'h0, {31'h0, pin_level});
      rd_chk(8'h08);
      vfetch <= 1'b1;
      @(posedge sys_clk);
      vfetch <= 1'b0;
      @(posedge sys_clk);
      chk("int_request", 32'h0, {31'h0, int_req});
      rd_chk(8'h00);
      rise();
      slow <= 1'b0;
   endtask : t_edge

   task t_soft;
      wr(8'h04);
      fall();
      wr(8'h04);
      chk("int_request", 32'h0, {31'h0, int_req});
      rd_chk(8'h00);
      rise();
   endtask : t_soft

   task t_mask;
      wr(8'h02);
      rd_chk(8'h02);
      low_req <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("int_request", 32'h0, {31'h0, int_req});
      rd_chk(8'h0A);
      wr(8'h00);
      wait_req(1'b1);
      ccw_mask <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("int_request", 32'h0, {31'h0, int_req});
      ccw_mask <= 1'b0;
      wr(8'h04);
      rise();
   endtask : t_mask

   task t_level;
      wr(8'h01);
      rd_chk(8'h01);
      fall();
      wr(8'h07);
      repeat (4) @(posedge sys_clk);
      rd_chk(8'h0B);
      chk("int_request", 32'h0, {31'h0, int_req});
      rise();
      rd_chk(8'h03);
      wr(8'h01);
      fall();
      rise();
      rd_chk(8'h09);
      wr(8'h05);
      rd_chk(8'h01);
      wr(8'h00);
   endtask : t_level

   task t_break;
      fall();
      rise();
      brk <= 1'b1;
      wr(8'h04);
      rd_chk(8'h08);
      brk_clr <= 1'b1;
      wr(8'h04);
      brk <= 1'b0;
      brk_clr <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd_chk(8'h00);
   endtask : t_break

   // Reset in mid-run while the line stays low
   task t_rst;
      wr(8'h03);
      wr(8'h01);
      fall();
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk("int_request", 32'h0, {31'h0, int_req});
      rd_chk(8'h00);
      repeat (6) @(posedge sys_clk);
      chk("int_request", 32'h0, {31'h0, int_req});
      rise();
   endtask : t_rst

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // A hang is cut short well beyond the fewer than two hundred clocks needed
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         end_sim();
      end
   end

   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      low_req = 1'b0;
      slow = 1'b0;
      vfetch = 1'b0;
      ccw_mask = 1'b0;
      brk = 1'b0;
      brk_clr = 1'b0;
      errors = 0;
      num_checks = 0;
      cycles = 0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_edge();
      t_soft();
      t_mask();
      t_level();
      t_break();
      t_rst();
      end_sim();
   end
endmodule : eipl_top_test
